// ===== inc/eeprom_consts.vh
// Constants for the three-wire serial EEPROM instruction decoder.
// What this block does
// R01: A read is start bit 1, opcode 10 and a nine-bit (x8) or eight-bit (x16) address, after which the stored data are returned.
// R02: Opcode 00 with address beginning 11 enables programming, and erase or write commands are ignored until it has been taken.
// R03: Opcode 11 with a full address sets every bit of that location to one.
// R04: Opcode 01 with an address and then 8 or 16 data bits, most significant first, stores that pattern at the address.
// R05: Opcode 00 with address beginning 10 sets every bit of the whole array to one.
// R06: Opcode 00 with address beginning 01 and one data word writes that word everywhere, only while programming is enabled.
// R07: Opcode 00 with address beginning 00 disables programming, so erase and write are rejected while reads still work.
// R08: The host clocks every don't-care address bit, including the unused top bit, so the full field is counted.
// R09: The organization input high selects 16-bit words and low selects 8-bit words, setting address and data widths.
// R10: Programming is disabled after reset and stays enabled after an enable command until a disable command.
// R11: A read drives one zero bit before the first word and then streams consecutive locations without further zeros while select is high.
// R12: The programming cycle starts right after the last data bit is received.
// R13: Only the first time select is dropped and raised during a programming cycle does the output show zero while busy and one when done.
// R14: A command starts with select high, leading zeros are skipped until a one which is the start bit, and input is sampled on rising serial clock edges.
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH
`define OP_MISC 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3
`define SUB_DISABLE 2'h0
`define SUB_BULK_WRITE 2'h1
`define SUB_BULK_ERASE 2'h2
`define SUB_ENABLE 2'h3
`define ADDR_BITS_X8 5'h09
`define ADDR_BITS_X16 5'h08
`define DATA_BITS_X8 5'h08
`define DATA_BITS_X16 5'h10
`define LAST_BYTE 9'h1ff
`define ERASED_WORD 16'hffff
`define PROG_TIME_MS 10
`define CLK_FREQ_KHZ 200000
`define PROG_CYCLES (`PROG_TIME_MS * `CLK_FREQ_KHZ)
`endif

// ===== verilog/eeprom_byte_array.v
// Byte-wide storage array with registered read data.
`timescale 1ns/1ps
module eeprom_byte_array (
	input wire clk,
	input wire rst,
	input wire [8:0] addr,
	input wire wr_en,
	input wire [7:0] wr_data,
	output reg [7:0] rd_data
);
	reg [7:0] mem [0:511];

	// Array write; contents have no reset, like a real cell array.
	always @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	// Registered read port.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= mem[addr];
		end
	end
endmodule // eeprom_byte_array

// ===== verilog/serial_eeprom_instruction_decoder.v
// Instruction decoder and command sequencer of a three-wire serial EEPROM.
`timescale 1ns/1ps
`include "eeprom_consts.vh"
module serial_eeprom_instruction_decoder #(
	parameter [31:0] PROG_CYCLES = `PROG_CYCLES
) (
	input wire clk,
	input wire rst,
	input wire chip_select,
	input wire serial_clock,
	input wire serial_in,
	input wire word_width_select,
	output wire serial_out,
	output wire serial_out_en_n
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_OP = 3'h1;
	localparam [2:0] S_ADDR = 3'h2;
	localparam [2:0] S_DATA = 3'h3;
	localparam [2:0] S_READ = 3'h4;
	localparam [2:0] S_HOLD = 3'h5;

	reg [1:0] cs_sync_reg, sk_sync_reg, di_sync_reg, org_sync_reg, op_reg, fetch_reg;
	reg sk_prev_reg, cs_prev_reg, prog_en_reg, go_pg_reg, go_all_reg, rd_go_reg;
	reg busy_reg, walk_reg, pat_word_reg, armed_reg, show_reg, out_reg, oe_n_reg;
	reg [2:0] state_reg;
	reg [4:0] bit_cnt_reg, left_reg;
	reg [8:0] addr_reg, ptr_reg, last_reg, rd_addr_reg, mem_addr;
	reg [15:0] data_reg, go_pat_reg, pat_reg, shift_reg, next_reg;
	reg [31:0] timer_reg;
	wire [7:0] mem_rd_data;

	wire cs = cs_sync_reg[1];
	wire di = di_sync_reg[1];
	wire word_mode = org_sync_reg[1];
	wire sk_rise = sk_sync_reg[1] & ~sk_prev_reg;
	wire cs_rise = cs & ~cs_prev_reg;
	wire [4:0] addr_len = word_mode ? `ADDR_BITS_X16 : `ADDR_BITS_X8; // R09
	wire [4:0] data_len = word_mode ? `DATA_BITS_X16 : `DATA_BITS_X8; // R09
	wire [8:0] addr_shift = {addr_reg[7:0], di};
	wire [1:0] sub_op = word_mode ? addr_shift[7:6] : addr_shift[8:7];
	wire [15:0] data_shift = {data_reg[14:0], di};
	wire addr_done = (bit_cnt_reg == addr_len - 5'h01); // R08
	wire data_done = (bit_cnt_reg == data_len - 5'h01);
	wire [7:0] wr_byte = (pat_word_reg & ~ptr_reg[0]) ? pat_reg[15:8] : pat_reg[7:0];

	assign serial_out = out_reg;
	assign serial_out_en_n = oe_n_reg;

	// Two-flop synchronisers for every input pin, plus edge history of the clock and select second flops.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_sync_reg <= 2'h0;
			sk_sync_reg <= 2'h0;
			di_sync_reg <= 2'h0;
			org_sync_reg <= 2'h0;
			sk_prev_reg <= 1'b0;
			cs_prev_reg <= 1'b0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[0], chip_select};
			sk_sync_reg <= {sk_sync_reg[0], serial_clock};
			di_sync_reg <= {di_sync_reg[0], serial_in};
			org_sync_reg <= {org_sync_reg[0], word_width_select};
			sk_prev_reg <= sk_sync_reg[1];
			cs_prev_reg <= cs_sync_reg[1];
		end
	end

	// Command decoder: collects start bit, opcode, address and data on rising serial clock edges.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			bit_cnt_reg <= 5'h00;
			op_reg <= 2'h0;
			addr_reg <= 9'h000;
			data_reg <= 16'h0000;
			prog_en_reg <= 1'b0; // R10
			go_pg_reg <= 1'b0;
			go_all_reg <= 1'b0;
			go_pat_reg <= 16'h0000;
			rd_go_reg <= 1'b0;
		end else begin
			go_pg_reg <= 1'b0;
			rd_go_reg <= 1'b0;
			if (!cs) begin
				state_reg <= S_IDLE; // R14
			end else if (sk_rise) begin
				case (state_reg)
					S_IDLE: begin
						// Leading zeros are skipped; a busy device takes no command.
						if (di && !busy_reg) begin
							state_reg <= S_OP; // R14
							bit_cnt_reg <= 5'h00;
						end
					end
					S_OP: begin
						op_reg <= {op_reg[0], di};
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (bit_cnt_reg == 5'h01) begin
							state_reg <= S_ADDR;
							bit_cnt_reg <= 5'h00;
						end
					end
					S_ADDR: begin
						addr_reg <= addr_shift;
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (addr_done) begin
							bit_cnt_reg <= 5'h00;
							state_reg <= S_HOLD;
							case (op_reg)
								`OP_READ: begin
									state_reg <= S_READ; // R01
									rd_go_reg <= 1'b1;
								end
								`OP_ERASE: begin
									go_pg_reg <= prog_en_reg; // R03 R02
									go_all_reg <= 1'b0;
									go_pat_reg <= `ERASED_WORD;
								end
								`OP_WRITE: begin
									state_reg <= S_DATA; // R04
								end
								default: begin
									case (sub_op)
										`SUB_ENABLE: prog_en_reg <= 1'b1; // R02
										`SUB_DISABLE: prog_en_reg <= 1'b0; // R07
										`SUB_BULK_ERASE: begin
											go_pg_reg <= prog_en_reg; // R05
											go_all_reg <= 1'b1;
											go_pat_reg <= `ERASED_WORD;
										end
										default: state_reg <= S_DATA; // R06
									endcase
								end
							endcase
						end
					end
					S_DATA: begin
						data_reg <= data_shift;
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (data_done) begin
							// Programming starts as soon as the last data bit is in.
							state_reg <= S_HOLD;
							go_pg_reg <= prog_en_reg; // R12 R06 R07
							go_all_reg <= (op_reg == `OP_MISC);
							go_pat_reg <= data_shift; // R04
						end
					end
					default: state_reg <= state_reg;
				endcase
			end
		end
	end

	// Self-timed programming engine: walks the target bytes while the cycle timer runs, busy until both are done.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_reg <= 1'b0;
			walk_reg <= 1'b0;
			ptr_reg <= 9'h000;
			last_reg <= 9'h000;
			pat_reg <= 16'h0000;
			pat_word_reg <= 1'b0;
			timer_reg <= 32'h00000000;
		end else if (go_pg_reg) begin
			busy_reg <= 1'b1; // R12
			walk_reg <= 1'b1;
			timer_reg <= 32'h00000000;
			pat_reg <= go_pat_reg;
			pat_word_reg <= word_mode;
			if (go_all_reg) begin
				ptr_reg <= 9'h000; // R05 R06
				last_reg <= `LAST_BYTE;
			end else if (word_mode) begin
				ptr_reg <= {addr_reg[7:0], 1'b0};
				last_reg <= {addr_reg[7:0], 1'b1};
			end else begin
				ptr_reg <= addr_reg;
				last_reg <= addr_reg;
			end
		end else if (busy_reg) begin
			if (walk_reg) begin
				if (ptr_reg == last_reg) begin
					walk_reg <= 1'b0;
				end else begin
					ptr_reg <= ptr_reg + 9'h001;
				end
			end
			if (timer_reg < PROG_CYCLES - 32'h00000001) begin
				timer_reg <= timer_reg + 32'h00000001;
			end else if (!walk_reg) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// Ready/busy status is offered only on a select rise inside a programming cycle.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			armed_reg <= 1'b0;
			show_reg <= 1'b0;
		end else if (go_pg_reg) begin
			armed_reg <= 1'b1;
			show_reg <= 1'b0;
		end else if (!cs) begin
			show_reg <= 1'b0;
			if (show_reg || !busy_reg) begin
				armed_reg <= 1'b0;
			end
		end else if (cs_rise && armed_reg && busy_reg) begin
			show_reg <= 1'b1; // R13
		end else if (state_reg == S_OP) begin
			show_reg <= 1'b0;
			armed_reg <= 1'b0;
		end
	end

	// Memory address: the programming walk owns the port, otherwise the read prefetch.
	always @* begin
		if (busy_reg) begin
			mem_addr = ptr_reg;
		end else if (fetch_reg == 2'h2) begin
			mem_addr = {rd_addr_reg[7:0], 1'b1};
		end else if (word_mode) begin
			mem_addr = {rd_addr_reg[7:0], 1'b0};
		end else begin
			mem_addr = rd_addr_reg;
		end
	end

	eeprom_byte_array i_eeprom_byte_array (
		.clk(clk),
		.rst(rst),
		.addr(mem_addr),
		.wr_en(busy_reg & walk_reg),
		.wr_data(wr_byte),
		.rd_data(mem_rd_data)
	);

	// Serial output: dummy zero, streamed read data with prefetch, or ready/busy status.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			out_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			shift_reg <= 16'h0000;
			left_reg <= 5'h00;
			rd_addr_reg <= 9'h000;
			next_reg <= 16'h0000;
			fetch_reg <= 2'h0;
		end else begin
			case (fetch_reg)
				2'h1: fetch_reg <= 2'h2;
				2'h2: begin
					if (word_mode) begin
						next_reg[15:8] <= mem_rd_data;
						fetch_reg <= 2'h3;
					end else begin
						next_reg <= {8'h00, mem_rd_data};
						fetch_reg <= 2'h0;
					end
				end
				2'h3: begin
					next_reg[7:0] <= mem_rd_data;
					fetch_reg <= 2'h0;
				end
				default: fetch_reg <= 2'h0;
			endcase
			if (!cs) begin
				oe_n_reg <= 1'b1;
				out_reg <= 1'b1;
			end else if (show_reg) begin
				oe_n_reg <= 1'b0;
				out_reg <= ~busy_reg; // R13
			end else if (rd_go_reg) begin
				oe_n_reg <= 1'b0;
				out_reg <= 1'b0; // R11
				left_reg <= 5'h00;
				rd_addr_reg <= word_mode ? {1'b0, addr_reg[7:0]} : addr_reg; // R01
				fetch_reg <= 2'h1;
			end else if (state_reg == S_READ && sk_rise) begin
				if (left_reg == 5'h00) begin
					// Next word goes straight out with no dummy bit.
					out_reg <= word_mode ? next_reg[15] : next_reg[7]; // R11
					shift_reg <= word_mode ? {next_reg[14:0], 1'b0} : {next_reg[6:0], 9'h000};
					left_reg <= data_len - 5'h01;
					rd_addr_reg <= word_mode ? {1'b0, rd_addr_reg[7:0] + 8'h01} : rd_addr_reg + 9'h001; // R11
					fetch_reg <= 2'h1;
				end else begin
					out_reg <= shift_reg[15];
					shift_reg <= {shift_reg[14:0], 1'b0};
					left_reg <= left_reg - 5'h01;
				end
			end else if (state_reg != S_READ) begin
				oe_n_reg <= 1'b1;
				out_reg <= 1'b1;
			end
		end
	end
endmodule // serial_eeprom_instruction_decoder

// ===== verif/serial_eeprom_instruction_decoder_checker.sv
// Checker of the serial EEPROM decoder output pins.
`timescale 1ns/1ps
module serial_eeprom_instruction_decoder_checker #(
	parameter [31:0] PROG_CYCLES = 32'd600
) (
	input wire clk,
	input wire rst,
	input wire chip_select,
	input wire serial_clock,
	input wire serial_in,
	input wire word_width_select,
	input wire serial_out,
	input wire serial_out_en_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [2:0] low_cnt;
	// Counts samples with select low, saturating at seven.
	always @(posedge clk or posedge rst) begin
		if (rst)
			low_cnt <= 3'h0;
		else if (chip_select)
			low_cnt <= 3'h0;
		else if (low_cnt != 3'h7)
			low_cnt <= low_cnt + 3'h1;
	end
	property p_release; $fell(chip_select) |-> ##[2:6] serial_out_en_n; endproperty
	a_release: assert property (p_release) else $error("pin not released");
	property p_quiet; low_cnt >= 3'h6 |-> serial_out_en_n && serial_out; endproperty
	a_quiet: assert property (p_quiet) else $error("driven while deselected");
	property p_idle; serial_out_en_n |-> serial_out; endproperty
	a_idle: assert property (p_idle) else $error("undriven output low");
	property p_dummy; $fell(serial_out_en_n) |-> !serial_out; endproperty
	a_dummy: assert property (p_dummy) else $error("first driven bit not zero");
	property p_cause; $fell(serial_out_en_n) |-> $past(chip_select, 3); endproperty
	a_cause: assert property (p_cause) else $error("drive without select");
	property p_hold; !serial_out_en_n && chip_select |=> !serial_out_en_n; endproperty
	a_hold: assert property (p_hold) else $error("stream dropped under select");
	property p_rel_cause; $rose(serial_out_en_n) |-> !$past(chip_select, 2); endproperty
	a_rel_cause: assert property (p_rel_cause) else $error("early release");
	property p_edge; $fell(serial_out) && !$past(serial_out_en_n) |-> $past(serial_clock, 2);
	endproperty
	a_edge: assert property (p_edge) else $error("data moved without clock");
	c_read: cover property ($fell(serial_out_en_n));
	c_ready: cover property (!serial_out_en_n && $rose(serial_out));
	c_release: cover property ($rose(serial_out_en_n));
endmodule // serial_eeprom_instruction_decoder_checker

// ===== verif/host_bus_model.sv
// Host controller model driving the three-wire serial bus.
`timescale 1ns/1ps
module host_bus_model (
	input wire clk,
	input wire serial_out,
	input wire serial_out_en_n,
	output logic chip_select,
	output logic serial_clock,
	output logic serial_in
);
	// Bus idles deselected with the serial clock parked low.
	initial begin
		chip_select = 1'b0;
		serial_clock = 1'b0;
		serial_in = 1'b0;
	end
	// Each command starts with a fresh rise of select.
	task open_frame();
		@(negedge clk);
		chip_select = 1'b1;
		repeat (8) @(negedge clk);
	endtask
	// Clocks n bits out MSB first, every don't-care bit too, and gathers returned bits.
	task shift(input logic [31:0] v, input int n, output logic [31:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--) begin
			serial_clock = 1'b0;
			serial_in = v[i];
			repeat (16) @(negedge clk);
			serial_clock = 1'b1;
			repeat (8) @(negedge clk);
			r = {r[30:0], serial_out_en_n ? 1'bz : serial_out};
			repeat (8) @(negedge clk);
		end
	endtask
	// Drops select long enough for a status poll; data flips so it is never stale.
	task close_frame();
		@(negedge clk);
		serial_clock = 1'b0;
		chip_select = 1'b0;
		serial_in = ~serial_in;
		repeat (60) @(negedge clk);
	endtask
endmodule // host_bus_model

// ===== verif/serial_eeprom_instruction_decoder_tb_top.sv
// Self-checking bench of the serial EEPROM instruction decoder.
`timescale 1ns/1ps
module serial_eeprom_instruction_decoder_tb_top;
	localparam int PROG = 600;
	logic clk, rst, word_width_select;
	wire chip_select, serial_clock, serial_in, serial_out, serial_out_en_n;
	logic [7:0] mem [0:511];
	logic [31:0] seen, r;
	logic [31:0] q[$];
	int mismatches, n_tests;
	event ev;
	serial_eeprom_instruction_decoder #(.PROG_CYCLES(PROG)) i_serial_eeprom_instruction_decoder (
		.clk(clk), .rst(rst), .chip_select(chip_select), .serial_clock(serial_clock),
		.serial_in(serial_in), .word_width_select(word_width_select),
		.serial_out(serial_out), .serial_out_en_n(serial_out_en_n));
	host_bus_model i_host_bus_model (.clk(clk), .serial_out(serial_out),
		.serial_out_en_n(serial_out_en_n), .chip_select(chip_select),
		.serial_clock(serial_clock), .serial_in(serial_in));
	// Free running system clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	// Notes the expectation, then hands the result to the monitor.
	task give(input logic [31:0] v, input logic [31:0] exp);
		q.push_back(exp);
		seen = v;
		->ev;
		@(negedge clk);
	endtask
	// Monitor pairs each result with the oldest note.
	initial forever begin
		@(ev);
		check(seen, q.pop_front());
	end
	task cmd(input logic [1:0] op, input logic [8:0] a, input logic [15:0] d, input bit dat);
		int aw, dw;
		aw = word_width_select ? 8 : 9;
		dw = dat ? (word_width_select ? 16 : 8) : 0;
		i_host_bus_model.open_frame();
		i_host_bus_model.shift((((32'd4 + op) << aw) | a) << dw | d, 3 + aw + dw, r);
		i_host_bus_model.close_frame();
	endtask
	task misc(input logic [1:0] sub, input logic [15:0] d, input bit dat);
		cmd(2'h0, word_width_select ? {1'b0, sub, 6'h0} : {sub, 7'h0}, d, dat);
	endtask
	task store(input logic [8:0] a, input logic [15:0] d);
		if (word_width_select) begin
			mem[2 * a] = d[15:8];
			mem[2 * a + 1] = d[7:0];
		end else
			mem[a] = d[7:0];
	endtask
	task fill(input logic [15:0] d);
		for (int i = 0; i < 512; i++)
			mem[i] = i[0] ? d[7:0] : d[15:8];
	endtask
	// Polls ready status in a fresh frame; a dropped command shows nothing.
	task status(input bit busy);
		int k;
		i_host_bus_model.open_frame();
		give({serial_out_en_n, serial_out}, busy ? 0 : 3);
		k = 0;
		while (busy && serial_out !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		if (busy)
			give({serial_out_en_n, serial_out}, 1);
		i_host_bus_model.close_frame();
	endtask
	// Read after three leading zeros, checking the dummy bit and a stream of words.
	task rd(input logic [8:0] a, input int words);
		int aw, dw;
		logic [15:0] e;
		aw = word_width_select ? 8 : 9;
		dw = word_width_select ? 16 : 8;
		i_host_bus_model.open_frame();
		i_host_bus_model.shift((32'd6 << aw) | a, 6 + aw, r);
		give(r[0], 0);
		for (int w = 0; w < words; w++) begin
			i_host_bus_model.shift(0, dw, r);
			if (word_width_select)
				e = {mem[(2 * a + 2 * w) % 512], mem[(2 * a + 2 * w + 1) % 512]};
			else
				e = {8'h00, mem[(a + w) % 512]};
			give(r, e);
		end
		i_host_bus_model.close_frame();
	endtask
	task print_verdict();
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence through both organizations.
	initial begin
		logic [8:0] a;
		logic [15:0] d;
		rst = 1'b1;
		word_width_select = 1'b0;
		a = $urandom(86651);
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		a = $urandom % 511;
		d = $urandom % 256;
		cmd(2'h1, a, d, 1);
		status(0);
		misc(2'h3, 0, 0);
		misc(2'h2, 0, 0);
		fill(16'hffff);
		status(1);
		cmd(2'h1, a, d, 1);
		store(a, d);
		status(1);
		rd(a, 2);
		cmd(2'h3, a, 0, 0);
		store(a, 16'hffff);
		status(1);
		rd(a, 1);
		word_width_select = 1'b1;
		a = $urandom % 255;
		d = $urandom;
		misc(2'h1, d, 1);
		fill(d);
		status(1);
		rd(a, 2);
		// A reset in mid-run must fall back to the programming-disabled state.
		rst = 1'b1;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		cmd(2'h1, a, ~d, 1);
		status(0);
		misc(2'h3, 0, 0);
		d = $urandom;
		cmd(2'h1, a, d, 1);
		store(a, d);
		status(1);
		misc(2'h0, 0, 0);
		cmd(2'h1, a, ~d, 1);
		status(0);
		rd(a, 1);
		print_verdict();
	end
	// Watchdog cuts a hang short.
	initial begin
		repeat (80000) @(posedge clk);
		mismatches++;
		print_verdict();
	end
endmodule // serial_eeprom_instruction_decoder_tb_top
bind serial_eeprom_instruction_decoder serial_eeprom_instruction_decoder_checker
	#(.PROG_CYCLES(PROG_CYCLES)) i_checker (.clk(clk), .rst(rst), .chip_select(chip_select),
	.serial_clock(serial_clock), .serial_in(serial_in), .word_width_select(word_width_select),
	.serial_out(serial_out), .serial_out_en_n(serial_out_en_n));
